// File: design/bpbf_top.sv
// Buzzer pattern sequencer, sensor fault display and line-locked burst firing drive.
// Assumes event pulses and settings come from logic on clk; the line reference is an async pin.

`timescale 1ns/1ps
`default_nettype none

module bpbf_top #(
   parameter int TICK_CYCLES     = bpbf_pkg::TICK_CYCLES,
   parameter int LINE_TIMEOUT_CY = bpbf_pkg::LINE_TIMEOUT_CY,
   parameter int LINE_SPLIT_CY   = bpbf_pkg::LINE_SPLIT_CY
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire bpbf_pkg::bpbf_evt_t evt,
   input  wire logic                boil_mode,
   input  wire logic [7:0]          beep_duration_s,
   input  wire logic                sensor_fault,
   input  wire logic                unit_fahrenheit,
   input  wire logic                end_ack,
   input  wire logic [6:0]          power_pct,
   input  wire logic                line_ref,
   output var  logic                buzzer_q,
   output var  logic                busy_q,
   output var  bpbf_pkg::bpbf_disp_t disp_q,
   output var  logic                ssr_drive_q,
   output var  logic                line_ok_q,
   output var  logic                line_60hz_q
);

   // ************************************************************
   // Parameter checks and widths
   // ************************************************************
   if (TICK_CYCLES < 8 || LINE_SPLIT_CY < 2 || LINE_TIMEOUT_CY <= LINE_SPLIT_CY) begin : g_bad_param
      $error("bpbf_top: counts too small or timeout not above split");
   end

   localparam int TW = $clog2(TICK_CYCLES);
   localparam int LW = $clog2(LINE_TIMEOUT_CY + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   localparam logic [LW-1:0] LINE_TMO  = LW'(LINE_TIMEOUT_CY);
   localparam logic [LW-1:0] LINE_SPL  = LW'(LINE_SPLIT_CY);

   typedef struct packed {
      logic                 sync1;
      logic                 sync2;
      logic                 sync3;
      logic [TW-1:0]        tick_cnt;
      logic                 tick;
      bpbf_pkg::bpbf_seq_t  seq;
      logic                 busy;
      logic [1:0]           pat;
      logic [3:0]           idx;
      logic [2:0]           remain;
      logic [7:0]           repeat_left;
      logic                 repeat_on;
      logic                 buzzer;
      logic                 flash_phase;
      bpbf_pkg::bpbf_disp_t disp;
      logic [LW-1:0]        per_cnt;
      logic                 line_ok;
      logic                 line_60;
      logic [6:0]           acc;
      logic                 ssr;
   } bpbf_state_t;

   bpbf_state_t             q;
   bpbf_state_t             d;
   bpbf_pkg::bpbf_seg_t     seg_q;
   bpbf_pkg::bpbf_rom_addr_t rom_addr;

   assign rom_addr = {q.pat, q.idx};

   bpbf_pattern_rom u_rom (
      .clk    (clk),
      .resetn (resetn),
      .addr   (rom_addr),
      .data_q (seg_q)
   );

   // ************************************************************
   // Reduce pct/100 to lowest terms: {numerator, denominator}
   // ************************************************************
   function automatic logic [13:0] bpbf_reduce(input logic [6:0] pct);
      logic [6:0] n;
      logic [6:0] m;
      n = pct;
      m = bpbf_pkg::PCT_FULL;
      if (n[1:0] == 2'h0) begin
         n = n >> 2;
         m = m >> 2;
      end else if (!n[0]) begin
         n = n >> 1;
         m = m >> 1;
      end
      if (n % 7'h19 == 7'h00) begin
         n = n / 7'h19;
         m = m / 7'h19;
      end else if (n % 7'h05 == 7'h00) begin
         n = n / 7'h05;
         m = m / 7'h05;
      end
      return {n, m};
   endfunction

   logic [1:0] new_pat;
   logic [6:0] pct_lim;
   logic [6:0] num;
   logic [6:0] den;
   logic [7:0] sum;
   logic       line_edge;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;

      // Line reference synchroniser and rising edge of each line cycle
      d.sync1   = line_ref;
      d.sync2   = q.sync1;
      d.sync3   = q.sync2;
      line_edge = q.sync2 & ~q.sync3;

      // Trigger selection, program end first
      new_pat = bpbf_pkg::PAT_NONE;
      if (evt.program_end) begin
         new_pat = bpbf_pkg::PAT_END8;
      end else if ((!boil_mode && evt.step_end) || (boil_mode && evt.boil_event)) begin
         new_pat = bpbf_pkg::PAT_LONG4;
      end else if ((!boil_mode && evt.step_start) || (boil_mode && evt.boil_timer_start)) begin
         new_pat = bpbf_pkg::PAT_SHORT3;
      end

      // Common one second tick
      d.tick = 1'b0;
      if (new_pat != bpbf_pkg::PAT_NONE) begin
         d.tick_cnt = '0;
      end else if (q.tick_cnt == TICK_LAST) begin
         d.tick_cnt = '0;
         d.tick     = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 1'b1;
      end

      // Pattern sequencer
      if (new_pat != bpbf_pkg::PAT_NONE) begin
         d.pat         = new_pat;
         d.idx         = '0;
         d.seq         = bpbf_pkg::SEQ_ADDR;
         d.buzzer      = 1'b0;
         d.repeat_on   = boil_mode && evt.boil_event && (new_pat == bpbf_pkg::PAT_LONG4);
         d.repeat_left = beep_duration_s;
      end else begin
         if (q.tick && q.repeat_left != 8'h00) begin
            d.repeat_left = q.repeat_left - 8'h01;
         end
         unique case (q.seq)
            bpbf_pkg::SEQ_IDLE: begin
               d.buzzer = 1'b0;
            end
            bpbf_pkg::SEQ_ADDR: begin
               d.seq = bpbf_pkg::SEQ_FETCH;
            end
            bpbf_pkg::SEQ_FETCH: begin
               if (seg_q.valid) begin
                  d.buzzer = seg_q.tone;
                  d.remain = seg_q.dur;
                  d.seq    = bpbf_pkg::SEQ_RUN;
               end else if (q.repeat_on && q.repeat_left != 8'h00) begin
                  d.idx = '0;
                  d.seq = bpbf_pkg::SEQ_ADDR;
               end else begin
                  d.buzzer    = 1'b0;
                  d.repeat_on = 1'b0;
                  d.seq       = bpbf_pkg::SEQ_IDLE;
               end
            end
            bpbf_pkg::SEQ_RUN: begin
               if (q.tick) begin
                  if (q.remain == 3'h1) begin
                     d.buzzer = 1'b0;
                     d.idx    = q.idx + 4'h1;
                     d.seq    = bpbf_pkg::SEQ_ADDR;
                  end else begin
                     d.remain = q.remain - 3'h1;
                  end
               end
            end
         endcase
      end

      // End flash: a new program end wins over an acknowledge
      d.disp.end_flash = evt.program_end | (q.disp.end_flash & ~end_ack);

      // Sensor fault display alternates once per second
      if (q.tick) begin
         d.flash_phase = ~q.flash_phase;
      end
      d.disp.overrange = sensor_fault & q.flash_phase;
      if (!sensor_fault) begin
         d.disp.value = '0;
      end else if (unit_fahrenheit) begin
         d.disp.value = bpbf_pkg::OVR_VALUE_F;
      end else begin
         d.disp.value = bpbf_pkg::OVR_VALUE_C;
      end

      // Line period measure: frequency class and presence
      pct_lim    = (power_pct > bpbf_pkg::PCT_FULL) ? bpbf_pkg::PCT_FULL : power_pct;
      {num, den} = bpbf_reduce(pct_lim);
      sum        = {1'b0, q.acc} + {1'b0, num};
      if (line_edge) begin
         d.per_cnt = '0;
         d.line_ok = 1'b1;
         d.line_60 = (q.per_cnt < LINE_SPL);
         // Burst step on each line cycle start: whole-cycle pulses
         if (q.acc >= den) begin
            d.acc = '0;
            d.ssr = (num != 7'h00) && (num >= den);
         end else if (sum >= {1'b0, den}) begin
            d.acc = 7'(sum - {1'b0, den});
            d.ssr = 1'b1;
         end else begin
            d.acc = sum[6:0];
            d.ssr = 1'b0;
         end
      end else if (q.per_cnt >= LINE_TMO) begin
         d.line_ok = 1'b0;
         d.line_60 = 1'b0;
         d.ssr     = 1'b0;
         d.acc     = '0;
      end else begin
         d.per_cnt = q.per_cnt + 1'b1;
      end

      // Busy flag registered so the output comes from a flip-flop
      d.busy = (d.seq != bpbf_pkg::SEQ_IDLE);
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q     <= '0;
         q.seq <= bpbf_pkg::SEQ_IDLE;
      end else begin
         q <= d;
      end
   end

   assign buzzer_q    = q.buzzer;
   assign busy_q      = q.busy;
   assign disp_q      = q.disp;
   assign ssr_drive_q = q.ssr;
   assign line_ok_q   = q.line_ok;
   assign line_60hz_q = q.line_60;

endmodule

`default_nettype wire

// File: design/bpbf_pkg.sv
// Shared constants and carrier types for the beep pattern and burst fire block.
// Assumes a single 25 MHz clock and event pulses from logic on that clock.

package bpbf_pkg;

   // ************************************************************
   // Time base
   // ************************************************************
   localparam int CLK_HZ          = 25_000_000;
   localparam int SEC_TICK_S      = 1;
   localparam int TICK_CYCLES     = CLK_HZ * SEC_TICK_S;
   localparam int LINE_MIN_HZ     = 40;
   localparam int LINE_SPLIT_HZ   = 55;
   localparam int LINE_TIMEOUT_CY = CLK_HZ / LINE_MIN_HZ;
   localparam int LINE_SPLIT_CY   = CLK_HZ / LINE_SPLIT_HZ;

   // ************************************************************
   // Buzzer patterns and segment lengths in seconds
   // ************************************************************
   localparam logic [1:0] PAT_NONE   = 2'h0;
   localparam logic [1:0] PAT_LONG4  = 2'h1;
   localparam logic [1:0] PAT_SHORT3 = 2'h2;
   localparam logic [1:0] PAT_END8   = 2'h3;

   localparam logic [2:0] DUR_SHORT_BEEP_S  = 3'h1;
   localparam logic [2:0] DUR_LONG_BEEP_S   = 3'h2;
   localparam logic [2:0] DUR_END_BEEP_S    = 3'h5;
   localparam logic [2:0] DUR_SHORT_PAUSE_S = 3'h1;
   localparam logic [2:0] DUR_LONG_PAUSE_S  = 3'h2;

   localparam logic [3:0] LONG4_LAST  = 4'h6;
   localparam logic [3:0] SHORT3_LAST = 4'h4;
   localparam logic [3:0] END8_LAST   = 4'hE;
   localparam logic [3:0] LONG4_GAP2  = 4'h3;

   // ************************************************************
   // Display and power constants
   // ************************************************************
   localparam logic [9:0] OVR_VALUE_F = 10'h3A4;
   localparam logic [9:0] OVR_VALUE_C = 10'h1F4;
   localparam logic [6:0] PCT_FULL    = 7'h64;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'h0,
      SEQ_ADDR  = 2'h1,
      SEQ_FETCH = 2'h3,
      SEQ_RUN   = 2'h2
   } bpbf_seq_t;

   typedef struct packed {
      logic [1:0] pat;
      logic [3:0] idx;
   } bpbf_rom_addr_t;

   typedef struct packed {
      logic       valid;
      logic       tone;
      logic [2:0] dur;
   } bpbf_seg_t;

   typedef struct packed {
      logic step_end;
      logic step_start;
      logic boil_event;
      logic boil_timer_start;
      logic program_end;
   } bpbf_evt_t;

   typedef struct packed {
      logic       overrange;
      logic [9:0] value;
      logic       end_flash;
   } bpbf_disp_t;

endpackage

// File: design/bpbf_pattern_rom.sv
// Segment table for the buzzer patterns, with registered read data.
// Assumes the address is held stable for the cycle before the data is used.

`timescale 1ns/1ps
`default_nettype none

module bpbf_pattern_rom (
   input  wire logic                    clk,
   input  wire logic                    resetn,
   input  wire bpbf_pkg::bpbf_rom_addr_t addr,
   output var  bpbf_pkg::bpbf_seg_t     data_q
);

   bpbf_pkg::bpbf_seg_t data_d;

   // ************************************************************
   // Table contents: even entries sound, odd entries pause
   // ************************************************************
   always_comb begin
      data_d = '0;
      unique case (addr.pat)
         bpbf_pkg::PAT_LONG4: begin
            if (addr.idx <= bpbf_pkg::LONG4_LAST) begin
               data_d.valid = 1'b1;
               data_d.tone  = ~addr.idx[0];
               if (!addr.idx[0]) begin
                  data_d.dur = bpbf_pkg::DUR_LONG_BEEP_S;
               end else if (addr.idx == bpbf_pkg::LONG4_GAP2) begin
                  data_d.dur = bpbf_pkg::DUR_LONG_PAUSE_S;
               end else begin
                  data_d.dur = bpbf_pkg::DUR_SHORT_PAUSE_S;
               end
            end
         end
         bpbf_pkg::PAT_SHORT3: begin
            if (addr.idx <= bpbf_pkg::SHORT3_LAST) begin
               data_d.valid = 1'b1;
               data_d.tone  = ~addr.idx[0];
               data_d.dur   = addr.idx[0] ? bpbf_pkg::DUR_SHORT_PAUSE_S : bpbf_pkg::DUR_SHORT_BEEP_S;
            end
         end
         bpbf_pkg::PAT_END8: begin
            if (addr.idx <= bpbf_pkg::END8_LAST) begin
               data_d.valid = 1'b1;
               data_d.tone  = ~addr.idx[0];
               data_d.dur   = addr.idx[0] ? bpbf_pkg::DUR_LONG_PAUSE_S : bpbf_pkg::DUR_END_BEEP_S;
            end
         end
         bpbf_pkg::PAT_NONE: begin
            data_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_q <= '0;
      end else begin
         data_q <= data_d;
      end
   end

endmodule

`default_nettype wire

// File: verification/bpbf_chk.sv
// Port checks for bpbf_top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bpbf_chk #(
   parameter int TICK_CYCLES     = 16,
   parameter int LINE_TIMEOUT_CY = 400,
   parameter int LINE_SPLIT_CY   = 200
) (
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire bpbf_pkg::bpbf_evt_t  evt,
   input wire logic                 boil_mode,
   input wire logic [7:0]           beep_duration_s,
   input wire logic                 sensor_fault,
   input wire logic                 unit_fahrenheit,
   input wire logic                 end_ack,
   input wire logic [6:0]           power_pct,
   input wire logic                 line_ref,
   input wire logic                 buzzer_q,
   input wire logic                 busy_q,
   input wire bpbf_pkg::bpbf_disp_t disp_q,
   input wire logic                 ssr_drive_q,
   input wire logic                 line_ok_q,
   input wire logic                 line_60hz_q
);
   typedef struct packed {
      logic        lvl;
      logic [15:0] still;
   } bpbf_chk_st_t;
   bpbf_chk_st_t st_q;
   bpbf_chk_st_t st_d;
   // Counts cycles since the line pin last moved
   always_comb begin
      st_d = st_q;
      st_d.lvl = line_ref;
      st_d.still = (line_ref != st_q.lvl) ? 16'h0000 : st_q.still + {15'h0000, ~&st_q.still};
   end
   always_ff @(posedge clk) begin
      if (!resetn)
         st_q <= '0;
      else
         st_q <= st_d;
   end
   default clocking dck @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_launch;
      ##1 busy_q ##2 buzzer_q;
   endsequence
   sequence s_line_edge;
      $rose(line_ref) && line_ok_q;
   endsequence
   a_end_launch: assert property (evt.program_end |-> s_launch)
      else $error("program end did not start");
   a_mash_launch: assert property (!boil_mode && evt == 5'h08 |-> s_launch)
      else $error("step start did not start");
   a_mode_gate: assert property (boil_mode && evt == 5'h08 && !busy_q |=> !busy_q)
      else $error("mash event taken in boil mode");
   a_buzz_busy: assert property (!busy_q |-> !buzzer_q)
      else $error("buzzer on while idle");
   a_fault_f: assert property (sensor_fault && unit_fahrenheit |=> disp_q.value == bpbf_pkg::OVR_VALUE_F)
      else $error("wrong fault value F");
   a_fault_c: assert property (sensor_fault && !unit_fahrenheit |=> disp_q.value == bpbf_pkg::OVR_VALUE_C)
      else $error("wrong fault value C");
   a_fault_none: assert property (!sensor_fault |=> disp_q.value == 10'h000)
      else $error("value shown without fault");
   a_flash_set: assert property (evt.program_end |=> disp_q.end_flash)
      else $error("end flash not set");
   a_flash_ack: assert property (end_ack && !evt.program_end |=> !disp_q.end_flash)
      else $error("end flash not cleared");
   a_full_power: assert property (s_line_edge ##0 power_pct == bpbf_pkg::PCT_FULL |-> ##[3:5] ssr_drive_q)
      else $error("full power cycle skipped");
   a_ssr_edge: assert property ($changed(ssr_drive_q) && line_ok_q |->
      ($past(line_ref, 3) && !$past(line_ref, 4)) || ($past(line_ref, 4) && !$past(line_ref, 5))
      || ($past(line_ref, 5) && !$past(line_ref, 6)))
      else $error("relay moved off a line edge");
   a_line_loss: assert property (st_q.still > 16'(LINE_TIMEOUT_CY + 8) |-> !line_ok_q && !ssr_drive_q)
      else $error("line loss not seen");
endmodule
bind bpbf_top bpbf_chk #(
   .TICK_CYCLES(TICK_CYCLES), .LINE_TIMEOUT_CY(LINE_TIMEOUT_CY), .LINE_SPLIT_CY(LINE_SPLIT_CY)
) u_chk (
   .clk(clk), .resetn(resetn), .evt(evt), .boil_mode(boil_mode), .beep_duration_s(beep_duration_s),
   .sensor_fault(sensor_fault), .unit_fahrenheit(unit_fahrenheit), .end_ack(end_ack), .power_pct(power_pct),
   .line_ref(line_ref), .buzzer_q(buzzer_q), .busy_q(busy_q), .disp_q(disp_q), .ssr_drive_q(ssr_drive_q),
   .line_ok_q(line_ok_q), .line_60hz_q(line_60hz_q)
);
`default_nettype wire

// File: verification/bpbf_far_model.sv
// Line source, relay and buzzer seen from the block's outputs.
// Assumes the bench sets run and the half period in ns.
`timescale 1ns/1ps
`default_nettype none
module bpbf_far_model (
   input  wire logic        ssr_drive,
   input  wire logic        buzzer,
   input  wire logic        run,
   input  wire logic [15:0] half_ns,
   output var  logic        line_ref,
   output wire logic [15:0] cyc_cnt,
   output wire logic [15:0] on_cnt,
   output wire logic [15:0] same_cnt,
   output wire logic [15:0] beep_cnt
);
   logic [15:0] cyc   = 16'h0000;
   logic [15:0] ons   = 16'h0000;
   logic [15:0] same  = 16'h0000;
   logic [15:0] beeps = 16'h0000;
   logic        prev  = 1'b0;
   assign cyc_cnt  = cyc;
   assign on_cnt   = ons;
   assign same_cnt = same;
   assign beep_cnt = beeps;
   always @(posedge buzzer) beeps <= beeps + 16'h0001;
   // Load conducts for whole cycles, judged mid-cycle
   always begin
      if (run) begin
         line_ref = 1'b1;
         #(half_ns);
         cyc = cyc + 16'h0001;
         ons = ons + {15'h0000, ssr_drive};
         same = same + {15'h0000, ssr_drive == prev};
         prev = ssr_drive;
         line_ref = 1'b0;
         #(half_ns);
      end else begin
         line_ref = 1'b0;
         #1000;
      end
   end
endmodule
`default_nettype wire

// File: verification/bpbf_top_bench.sv
// Self-checking bench for bpbf_top with the far side model.
// Assumes a 16 cycle tick and shortened line limits.
`timescale 1ns/1ps
`default_nettype none
module bpbf_top_bench;
   localparam int TK = 16;
   logic                 clk = 1'b0;
   logic                 resetn = 1'b0;
   bpbf_pkg::bpbf_evt_t  evt = '0;
   logic                 boil_mode = 1'b0;
   logic [7:0]           beep_duration_s = 8'h00;
   logic                 sensor_fault = 1'b0;
   logic                 unit_fahrenheit = 1'b0;
   logic                 end_ack = 1'b0;
   logic [6:0]           power_pct = 7'h00;
   logic                 run = 1'b0;
   // Whole clock periods keep line edges off the rising clock edge
   logic [15:0]          half_ns = 16'h0BB8;
   logic                 line_ref, buzzer_q, busy_q, ssr_drive_q, line_ok_q, line_60hz_q;
   bpbf_pkg::bpbf_disp_t disp_q;
   logic [15:0]          cyc_cnt, on_cnt, same_cnt, beep_cnt;
   int                   num_errors = 0;
   int                   checked = 0;
   int                   cycles = 0;
   bpbf_top #(.TICK_CYCLES(TK), .LINE_TIMEOUT_CY(400), .LINE_SPLIT_CY(200)) DUT (
      .clk(clk), .resetn(resetn), .evt(evt), .boil_mode(boil_mode), .beep_duration_s(beep_duration_s),
      .sensor_fault(sensor_fault), .unit_fahrenheit(unit_fahrenheit), .end_ack(end_ack), .power_pct(power_pct),
      .line_ref(line_ref), .buzzer_q(buzzer_q), .busy_q(busy_q), .disp_q(disp_q), .ssr_drive_q(ssr_drive_q),
      .line_ok_q(line_ok_q), .line_60hz_q(line_60hz_q));
   bpbf_far_model u_far (
      .ssr_drive(ssr_drive_q), .buzzer(buzzer_q), .run(run), .half_ns(half_ns), .line_ref(line_ref),
      .cyc_cnt(cyc_cnt), .on_cnt(on_cnt), .same_cnt(same_cnt), .beep_cnt(beep_cnt));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         close_out();
      end
   end
   // ****************
   // Helpers
   // ****************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [4:0] e);
      evt = bpbf_pkg::bpbf_evt_t'(e);
      step(1);
      evt = '0;
   endtask
   task automatic wait_cyc(input int n);
      logic [15:0] t;
      t = cyc_cnt + 16'(n);
      while (cyc_cnt != t) step(1);
   endtask
   // Measures buzzer runs in ticks against nibbles of exp
   task automatic capture(input logic [63:0] exp, input int n);
      int   k, len;
      logic lvl;
      k = 0;
      while (buzzer_q !== 1'b1) step(1);
      while (busy_q === 1'b1) begin
         lvl = buzzer_q;
         len = 0;
         while (buzzer_q === lvl && busy_q === 1'b1) begin
            step(1);
            len++;
         end
         if (len > TK / 2) begin
            if (k < n) check(32'((len + TK / 2) / TK), 32'(exp[4 * (n - 1 - k) +: 4]));
            k++;
         end
      end
      check(32'(k), 32'(n));
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_mash;
      pulse(5'h08);
      capture(64'h11111, 5);
      pulse(5'h10);
      capture(64'h2122212, 7);
      pulse(5'h10);
      while (buzzer_q !== 1'b1) step(1);
      while (buzzer_q === 1'b1) step(1);
      step(4);
      pulse(5'h08);
      capture(64'h11111, 5);
      $display("mash done");
   endtask
   task automatic t_end;
      logic [15:0] b0;
      b0 = beep_cnt;
      pulse(5'h01);
      check(32'(disp_q.end_flash), 32'h1);
      capture(64'h525252525252525, 15);
      check(32'(beep_cnt - b0), 32'h8);
      end_ack = 1'b1;
      step(2);
      check(32'(disp_q.end_flash), 32'h0);
      end_ack = 1'b0;
      $display("end done");
   endtask
   task automatic t_boil;
      boil_mode = 1'b1;
      pulse(5'h08);
      step(4);
      check(32'(busy_q), 32'h0);
      pulse(5'h02);
      capture(64'h11111, 5);
      beep_duration_s = 8'h14;
      pulse(5'h04);
      capture(64'h21222122122212, 14);
      beep_duration_s = 8'h01;
      pulse(5'h04);
      capture(64'h2122212, 7);
      boil_mode = 1'b0;
      $display("boil done");
   endtask
   task automatic t_fault;
      int   tg;
      logic p;
      sensor_fault = 1'b1;
      unit_fahrenheit = 1'b1;
      step(2);
      check(32'(disp_q.value), 32'h3A4);
      tg = 0;
      p = disp_q.overrange;
      for (int i = 0; i < 4 * TK; i++) begin
         step(1);
         if (disp_q.overrange !== p) tg++;
         p = disp_q.overrange;
      end
      check(32'(tg), 32'h4);
      unit_fahrenheit = 1'b0;
      step(2);
      check(32'(disp_q.value), 32'h1F4);
      sensor_fault = 1'b0;
      step(2);
      check(32'(disp_q.value), 32'h0);
      $display("fault done");
   endtask
   task automatic t_burst;
      logic [6:0]  pct [6] = '{7'h64, 7'h32, 7'h19, 7'h14, 7'h00, 7'h4B};
      logic [15:0] on0, sm0;
      run = 1'b1;
      wait_cyc(4);
      for (int i = 0; i < 6; i++) begin
         power_pct = pct[i];
         wait_cyc(3);
         on0 = on_cnt;
         sm0 = same_cnt;
         wait_cyc(20);
         check(32'(on_cnt - on0), 32'(pct[i]) / 5);
         if (pct[i] == 7'h32) check(32'(same_cnt - sm0), 32'h0);
      end
      check(32'({line_ok_q, line_60hz_q}), 32'h3);
      half_ns = 16'h1388;
      wait_cyc(3);
      check(32'(line_60hz_q), 32'h0);
      run = 1'b0;
      step(600);
      check(32'({line_ok_q, ssr_drive_q}), 32'h0);
      $display("burst done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 resetn = 1'b1;
      t_mash();
      t_end();
      t_boil();
      t_fault();
      t_burst();
      close_out();
   end
endmodule
`default_nettype wire
